// ---- rtl/tmr_pkg.sv ----
/*
 Package for the dual counter/timer block: register offsets, field positions,
 reset values, prescaler divisors, mode codes and the bus carrier structs.
 Assumes a classic Wishbone slave with 32-bit words and byte addresses.
*/
package tmr_pkg;
    // ==========================================================
    // Register byte addresses (word aligned except ADDR_CLOCK_CONTROL)
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8e; // Printed offset
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h04;
    localparam logic [7:0] ADDR_GATE_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_LOW_T0 = 8'h10;
    localparam logic [7:0] ADDR_HIGH_T0 = 8'h14;
    localparam logic [7:0] ADDR_LOW_T1 = 8'h18;
    localparam logic [7:0] ADDR_HIGH_T1 = 8'h1c;
    localparam logic [7:0] ADDR_T23_EXT = 8'h20;
    localparam logic [7:0] ADDR_T23_SPLIT = 8'h24;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ==========================================================
    // Field positions: clock control
    localparam int CK_PRESCALE_LSB = 0;
    localparam int CK_SEL_T0 = 2;
    localparam int CK_SEL_T1 = 3;
    localparam int CK_LO_T2 = 4;
    localparam int CK_HI_T2 = 5;
    localparam int CK_LO_T3 = 6;
    localparam int CK_HI_T3 = 7;
    // Mode select
    localparam int MD_MODE_T0_LSB = 0;
    localparam int MD_COUNT_T0 = 2;
    localparam int MD_GATE_T0 = 3;
    localparam int MD_MODE_T1_LSB = 4;
    localparam int MD_COUNT_T1 = 6;
    localparam int MD_GATE_T1 = 7;
    // Control status
    localparam int CS_RUN_T0 = 4;
    localparam int CS_OVF_T0 = 5;
    localparam int CS_RUN_T1 = 6;
    localparam int CS_OVF_T1 = 7;
    // Gate config
    localparam int GC_POL_A = 3;
    localparam int GC_POL_B = 7;
    // Interrupt enables, low two bits of the control-status word above byte 0
    localparam int CS_IE_T0 = 8;
    localparam int CS_IE_T1 = 9;
    // ==========================================================
    // Prescaler divisors
    localparam logic [5:0] DIV_12 = 6'd12;
    localparam logic [5:0] DIV_4 = 6'd4;
    localparam logic [5:0] DIV_48 = 6'd48;
    localparam logic [2:0] EXT_DIV_8_M1 = 3'd7;
    // ==========================================================
    // Mode codes
    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } mode_type;
    // Bus carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } wb_req_type;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_type;
endpackage : tmr_pkg

// ---- rtl/dual_counter_timer.sv ----
/*
 Dual counter/timer with four modes, shared prescaler and clock-control bits.
 Assumes count and gate pins synchronous to clk, external clock divided on its own edges,
 and a classic Wishbone master holding each request until ack.
*/
// Chosen here: register access over Wishbone.
// Behaviour
// R01 - Count when run and gate condition true
// R02 - Run bit never clears or preloads count
// R03 - Software preloads count before setting run
// R04 - Counter mode counts external pin falling edges
// R05 - Timer 0 clock: system or prescaled
// R06 - Timer 1 clock select, ignored in counter
// R07 - Prescaler: div12, div4, div48, ext/8
// R08 - External clock/8 resynchronised before use
// R09 - Mode field decodes four modes
// R10 - Mode register bit layout fixed
// R11 - Mode 0 13-bit, overflow at 0x1FFF
// R12 - Mode 1 full sixteen bits
// R13 - Mode 2 low byte reloads from high
// R14 - Overflow with enable requests interrupt
// R15 - Split low byte uses timer 0 controls
// R16 - Split high byte uses run_bit_t1, flag1
// R17 - Timer 1 in split: no pin, no flag
// R18 - Timer 1 mode 3 stops it
// R19 - Timer 1 uses gate_input_b and polarity
// R20 - High-byte selects for timers 2/3
// R21 - Low-byte selects for timers 2/3
// R22 - Pin falling edge from two samples
`timescale 1ns/100ps
module dual_counter_timer (
    input wire logic clk,
    input wire logic reset_n,
    input wire tmr_pkg::wb_req_type wb_req,
    output tmr_pkg::wb_rsp_type wb_rsp,
    input wire logic count_pin_a,
    input wire logic count_pin_b,
    input wire logic gate_input_a,
    input wire logic gate_input_b,
    input wire logic ext_clk,
    input wire logic split_t2,
    input wire logic split_t3,
    input wire logic ext_clk_tick,
    output logic irq_t0,
    output logic irq_t1,
    output logic t1_overflow_pulse,
    output logic hi_tick_t2,
    output logic lo_tick_t2,
    output logic hi_tick_t3,
    output logic lo_tick_t3
);
    import tmr_pkg::*;

    // ==========================================================
    // Registers
    logic [7:0] timer_clock_control_r; // Clock select and prescale
    logic [7:0] timer_mode_select_r;   // Gate, counter select, mode
    logic [7:0] run_flags_r;           // Run and overflow bits
    logic [1:0] irq_en_r;              // Interrupt enables
    logic [7:0] gate_input_config_r;   // Gate polarities
    logic [7:0] low_byte_t0_r;
    logic [7:0] high_byte_t0_r;
    logic [7:0] low_byte_t1_r;
    logic [7:0] high_byte_t1_r;
    logic [1:0] ext_clk_choice_r;      // Timers 2/3 external clock choice
    logic wb_ack_r;

    // Decoded bits
    logic [1:0] prescale_field;
    logic clk_sel_t0, clk_sel_t1;
    logic gate_en_t0, gate_en_t1;
    logic count_select_t0, count_select_t1;
    logic run_bit_t0, run_bit_t1;
    mode_type mode_field_t0, mode_field_t1;
    assign prescale_field = timer_clock_control_r[CK_PRESCALE_LSB +: 2];
    assign clk_sel_t0 = timer_clock_control_r[CK_SEL_T0];
    assign clk_sel_t1 = timer_clock_control_r[CK_SEL_T1];
    assign mode_field_t0 = mode_type'(timer_mode_select_r[MD_MODE_T0_LSB +: 2]); // R09 R10
    assign count_select_t0 = timer_mode_select_r[MD_COUNT_T0]; // R10
    assign gate_en_t0 = timer_mode_select_r[MD_GATE_T0]; // R10
    assign mode_field_t1 = mode_type'(timer_mode_select_r[MD_MODE_T1_LSB +: 2]); // R09 R10
    assign count_select_t1 = timer_mode_select_r[MD_COUNT_T1]; // R10
    assign gate_en_t1 = timer_mode_select_r[MD_GATE_T1]; // R10
    assign run_bit_t0 = run_flags_r[CS_RUN_T0];
    assign run_bit_t1 = run_flags_r[CS_RUN_T1];

    // ==========================================================
    // Bus decode
    logic bus_hit;
    logic wr_stb;
    assign bus_hit = wb_req.cyc && wb_req.stb && !wb_ack_r;
    assign wr_stb = bus_hit && wb_req.we && wb_req.sel[0];

    // Write strobe for one address, gated by the lane strobe passed in
    function automatic logic wr_at(input logic [7:0] a, input logic s, input logic [7:0] adr);
        wr_at = s && (adr == a);
    endfunction : wr_at

    // ==========================================================
    // Pin sampling: two samples give one falling edge
    logic [1:0] pin_a_s_r, pin_b_s_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_a_s_r <= 2'b00;
            pin_b_s_r <= 2'b00;
        end else begin
            pin_a_s_r <= {pin_a_s_r[0], count_pin_a}; // R22
            pin_b_s_r <= {pin_b_s_r[0], count_pin_b}; // R22
        end
    end
    logic fall_a, fall_b;
    assign fall_a = pin_a_s_r[1] && !pin_a_s_r[0]; // R04 R22
    assign fall_b = pin_b_s_r[1] && !pin_b_s_r[0]; // R04 R22

    // ==========================================================
    // External clock: divide by 8, then two-stage resync and edge detect
    logic [2:0] ext_div_r;
    logic ext_div_q_r;
    always_ff @(posedge ext_clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_div_r <= 3'd0;
            ext_div_q_r <= 1'b0;
        end else begin
            ext_div_r <= ext_div_r + 3'd1;
            if (ext_div_r == EXT_DIV_8_M1) begin
                ext_div_q_r <= !ext_div_q_r; // One toggle per eight edges
            end
        end
    end
    logic ext_sync1_r, ext_sync2_r, ext_sync3_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
            ext_sync3_r <= 1'b0;
        end else begin
            ext_sync1_r <= ext_div_q_r; // R08
            ext_sync2_r <= ext_sync1_r; // R08
            ext_sync3_r <= ext_sync2_r;
        end
    end
    logic ext8_tick;
    assign ext8_tick = ext_sync2_r ^ ext_sync3_r; // R08

    // ==========================================================
    // Prescaler: one free counter, terminal count picked by the field
    logic [5:0] pre_cnt_r;
    logic [5:0] pre_div;
    logic pre_tick;
    always_comb begin
        case (prescale_field)
            2'b00: pre_div = DIV_12; // R07
            2'b01: pre_div = DIV_4;  // R07
            2'b10: pre_div = DIV_48; // R07
            default: pre_div = DIV_12;
        endcase
    end
    // Wrap test uses >= so a field change never strands the counter past the end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_r <= 6'd0;
        end else if (pre_cnt_r >= pre_div - 6'd1) begin
            pre_cnt_r <= 6'd0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 6'd1;
        end
    end
    assign pre_tick = (prescale_field == 2'b11) ? ext8_tick : // R07
                      (pre_cnt_r >= pre_div - 6'd1);            // R07

    // Timers 2/3 source, used only for the tick outputs below
    logic [1:0] t23_ext_src;
    logic div12_free_r;
    logic [3:0] d12_cnt_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            d12_cnt_r <= 4'd0;
            div12_free_r <= 1'b0;
        end else begin
            div12_free_r <= (d12_cnt_r == 4'd10);
            d12_cnt_r <= (d12_cnt_r == 4'd11) ? 4'd0 : d12_cnt_r + 4'd1;
        end
    end
    assign t23_ext_src[0] = ext_clk_choice_r[0] ? ext_clk_tick : div12_free_r;
    assign t23_ext_src[1] = ext_clk_choice_r[1] ? ext_clk_tick : div12_free_r;

    // ==========================================================
    // Gating and tick selection
    logic pol_a, pol_b;
    logic gate_ok_t0, gate_ok_t1;
    logic tick_t0, tick_t1_int;
    logic en_t0_lo, en_t0_hi, en_t1;
    logic split_t0;
    assign pol_a = gate_input_config_r[GC_POL_A];
    assign pol_b = gate_input_config_r[GC_POL_B];
    assign gate_ok_t0 = !gate_en_t0 || (gate_input_a == pol_a); // R01
    assign gate_ok_t1 = !gate_en_t1 || (gate_input_b == pol_b); // R19
    assign split_t0 = (mode_field_t0 == MODE_SPLIT);
    assign tick_t0 = count_select_t0 ? fall_a : (clk_sel_t0 ? 1'b1 : pre_tick); // R04 R05
    assign tick_t1_int = clk_sel_t1 ? 1'b1 : pre_tick; // R06
    assign en_t0_lo = run_bit_t0 && gate_ok_t0 && tick_t0; // R01 R15
    // Split high byte: internal clock only, run by timer 1's run bit
    assign en_t0_hi = split_t0 && run_bit_t1 && (clk_sel_t0 ? 1'b1 : pre_tick); // R16
    // Timer 1: in split the mode alone runs it, and it never takes the pin
    always_comb begin
        if (mode_field_t1 == MODE_SPLIT) begin
            en_t1 = 1'b0; // R18
        end else if (split_t0) begin
            en_t1 = tick_t1_int; // R17 R18
        end else begin
            en_t1 = run_bit_t1 && gate_ok_t1 && (count_select_t1 ? fall_b : tick_t1_int); // R01 R06 R19
        end
    end

    // ==========================================================
    // Count step shared by both timers
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
    } step_type;
    function automatic step_type step(input mode_type m, input logic [7:0] lo,
                                      input logic [7:0] hi);
        step_type s;
        logic [13:0] c13;
        logic [16:0] c16;
        s = '{lo: lo, hi: hi, ovf: 1'b0};
        c13 = 14'd0;
        c16 = 17'd0;
        case (m)
            MODE_13BIT: begin
                c13 = {1'b0, hi, lo[4:0]} + 14'd1; // R11
                s.hi = c13[12:5];
                s.lo = {lo[7:5], c13[4:0]};
                s.ovf = c13[13]; // R11
            end
            MODE_16BIT: begin
                c16 = {1'b0, hi, lo} + 17'd1; // R12
                s.hi = c16[15:8];
                s.lo = c16[7:0];
                s.ovf = c16[16];
            end
            MODE_RELOAD: begin
                if (lo == 8'hff) begin
                    s.lo = hi; // R13
                    s.ovf = 1'b1; // R13
                end else begin
                    s.lo = lo + 8'd1;
                end
            end
            default: begin
                s.lo = lo + 8'd1; // Split low byte
                s.ovf = (lo == 8'hff);
            end
        endcase
        return s;
    endfunction : step

    step_type nx_t0, nx_t1;
    logic ovf_t0_ev, ovf_t1_ev, t1_wrap, hi_wrap;
    assign nx_t0 = step(mode_field_t0, low_byte_t0_r, high_byte_t0_r);
    assign nx_t1 = step(mode_field_t1, low_byte_t1_r, high_byte_t1_r);
    assign ovf_t0_ev = en_t0_lo && nx_t0.ovf; // R15
    assign hi_wrap = en_t0_hi && (high_byte_t0_r == 8'hff); // R16
    assign t1_wrap = en_t1 && nx_t1.ovf;
    assign ovf_t1_ev = split_t0 ? hi_wrap : t1_wrap; // R16 R17

    // ==========================================================
    // Timer 0 count bytes; a bus write wins over counting, run never preloads
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_byte_t0_r <= RST_BYTE;
            high_byte_t0_r <= RST_BYTE;
        end else begin
            if (wr_at(ADDR_LOW_T0, wr_stb, wb_req.adr)) begin
                low_byte_t0_r <= wb_req.dat[7:0]; // R03
            end else if (en_t0_lo) begin
                low_byte_t0_r <= nx_t0.lo; // R02
            end
            if (wr_at(ADDR_HIGH_T0, wr_stb, wb_req.adr)) begin
                high_byte_t0_r <= wb_req.dat[7:0];
            end else if (en_t0_hi) begin
                high_byte_t0_r <= high_byte_t0_r + 8'd1; // R16
            end else if (en_t0_lo && !split_t0) begin
                high_byte_t0_r <= nx_t0.hi; // R12
            end
        end
    end

    // Timer 1 count bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_byte_t1_r <= RST_BYTE;
            high_byte_t1_r <= RST_BYTE;
        end else begin
            if (wr_at(ADDR_LOW_T1, wr_stb, wb_req.adr)) begin
                low_byte_t1_r <= wb_req.dat[7:0];
            end else if (en_t1) begin
                low_byte_t1_r <= nx_t1.lo; // R02
            end
            if (wr_at(ADDR_HIGH_T1, wr_stb, wb_req.adr)) begin
                high_byte_t1_r <= wb_req.dat[7:0];
            end else if (en_t1) begin
                high_byte_t1_r <= nx_t1.hi;
            end
        end
    end

    // ==========================================================
    // Control status: overflow set wins over a software clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_flags_r <= RST_BYTE;
            irq_en_r <= 2'b00;
        end else begin
            if (wr_at(ADDR_CONTROL_STATUS, wr_stb, wb_req.adr)) begin
                run_flags_r <= wb_req.dat[7:0];
            end
            if (wr_at(ADDR_CONTROL_STATUS, bus_hit && wb_req.we && wb_req.sel[1],
                      wb_req.adr)) begin
                irq_en_r <= {wb_req.dat[CS_IE_T1], wb_req.dat[CS_IE_T0]};
            end
            if (ovf_t0_ev) begin
                run_flags_r[CS_OVF_T0] <= 1'b1; // R11 R13 R15
            end
            if (ovf_t1_ev) begin
                run_flags_r[CS_OVF_T1] <= 1'b1; // R16 R17
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_clock_control_r <= RST_BYTE;
            timer_mode_select_r <= RST_BYTE;
            gate_input_config_r <= RST_BYTE;
            ext_clk_choice_r <= 2'b00;
        end else begin
            if (wr_at(ADDR_CLOCK_CONTROL, wr_stb, wb_req.adr)) begin
                timer_clock_control_r <= wb_req.dat[7:0];
            end
            if (wr_at(ADDR_MODE_SELECT, wr_stb, wb_req.adr)) begin
                timer_mode_select_r <= wb_req.dat[7:0];
            end
            if (wr_at(ADDR_GATE_CONFIG, wr_stb, wb_req.adr)) begin
                gate_input_config_r <= wb_req.dat[7:0];
            end
            if (wr_at(ADDR_T23_EXT, wr_stb, wb_req.adr)) begin
                ext_clk_choice_r <= wb_req.dat[1:0];
            end
        end
    end

    // ==========================================================
    // Read mux; unmapped addresses read as zero and are still acked
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        case (wb_req.adr)
            ADDR_CLOCK_CONTROL: rd_data[7:0] = timer_clock_control_r;
            ADDR_MODE_SELECT: rd_data[7:0] = timer_mode_select_r;
            ADDR_CONTROL_STATUS: rd_data[9:0] = {irq_en_r, run_flags_r};
            ADDR_GATE_CONFIG: rd_data[7:0] = gate_input_config_r;
            ADDR_LOW_T0: rd_data[7:0] = low_byte_t0_r;
            ADDR_HIGH_T0: rd_data[7:0] = high_byte_t0_r;
            ADDR_LOW_T1: rd_data[7:0] = low_byte_t1_r;
            ADDR_HIGH_T1: rd_data[7:0] = high_byte_t1_r;
            ADDR_T23_EXT: rd_data[1:0] = ext_clk_choice_r;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_r <= 1'b0;
            wb_rsp <= '0;
        end else begin
            wb_ack_r <= bus_hit;
            wb_rsp.ack <= bus_hit;
            wb_rsp.dat <= bus_hit ? rd_data : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Outputs, all registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_t0 <= 1'b0;
            irq_t1 <= 1'b0;
            t1_overflow_pulse <= 1'b0;
            hi_tick_t2 <= 1'b0;
            lo_tick_t2 <= 1'b0;
            hi_tick_t3 <= 1'b0;
            lo_tick_t3 <= 1'b0;
        end else begin
            irq_t0 <= run_flags_r[CS_OVF_T0] && irq_en_r[0]; // R14
            irq_t1 <= run_flags_r[CS_OVF_T1] && irq_en_r[1]; // R14
            t1_overflow_pulse <= t1_wrap; // R17
            hi_tick_t2 <= split_t2 && (timer_clock_control_r[CK_HI_T2] || t23_ext_src[0]); // R20
            hi_tick_t3 <= split_t3 && (timer_clock_control_r[CK_HI_T3] || t23_ext_src[1]); // R20
            lo_tick_t2 <= timer_clock_control_r[CK_LO_T2] || t23_ext_src[0]; // R21
            lo_tick_t3 <= timer_clock_control_r[CK_LO_T3] || t23_ext_src[1]; // R21
        end
    end

    // ==========================================================
    // Checks
    a_halt_no_count: assert property (@(posedge clk) disable iff (!reset_n)
        (!run_bit_t0 && !wr_stb) |=> $stable(low_byte_t0_r)) // R01
        else $error("timer 0 low byte moved while stopped");
    a_t1_mode3_stop: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_field_t1 == MODE_SPLIT && !wr_stb) |=> $stable({high_byte_t1_r, low_byte_t1_r})) // R18
        else $error("timer 1 moved in mode 3");
    a_reload_value: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_field_t0 == MODE_RELOAD && en_t0_lo && low_byte_t0_r == 8'hff && !wr_stb)
        |=> low_byte_t0_r == $past(high_byte_t0_r)) // R13
        else $error("mode 2 reload wrong");
    a_ovf_sets: assert property (@(posedge clk) disable iff (!reset_n)
        ovf_t0_ev |=> run_flags_r[CS_OVF_T0]) // R11
        else $error("overflow flag 0 not set");
    a_split_flag1: assert property (@(posedge clk) disable iff (!reset_n)
        (split_t0 && !hi_wrap && !wr_stb) |=> $stable(run_flags_r[CS_OVF_T1])) // R17
        else $error("timer 1 set flag in split");
    a_irq_follows: assert property (@(posedge clk) disable iff (!reset_n)
        (run_flags_r[CS_OVF_T1] && irq_en_r[1]) |=> irq_t1) // R14
        else $error("irq 1 missing");
    a_pin_count: assert property (@(posedge clk) disable iff (!reset_n)
        (count_select_t0 && run_bit_t0 && !gate_en_t0 && !split_t0 && !fall_a && !wr_stb)
        |=> $stable(low_byte_t0_r)) // R04
        else $error("counter moved without pin edge");
    a_ack_one: assert property (@(posedge clk) disable iff (!reset_n)
        wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    a_mode0_hi: assert property (@(posedge clk) disable iff (!reset_n)
        (mode_field_t0 == MODE_13BIT && en_t0_lo && low_byte_t0_r[4:0] == 5'h1f && !wr_stb)
        |=> high_byte_t0_r == $past(high_byte_t0_r) + 8'd1) // R11
        else $error("13-bit carry wrong");
endmodule : dual_counter_timer

// ---- bench/pin_source.sv ----
/* Count-pin source for the timer bench: idle-high pins, bursts of falls.
 Assumes start is a one-cycle pulse while done is high. */
`timescale 1ns/100ps
module pin_source (
    input wire logic clk,
    input wire logic start,
    input wire logic pick_b,
    input wire logic [3:0] edges,
    output logic count_pin_a,
    output logic count_pin_b,
    output logic done
);
    // =====
    // Burst: each level held two cycles so a clk sampler never misses it
    initial begin
        {count_pin_a, count_pin_b, done} = 3'b111;
        forever begin
            @(posedge clk);
            if (start) begin
                done <= 1'b0;
                repeat (edges) begin
                    count_pin_a <= pick_b;
                    count_pin_b <= !pick_b;
                    repeat (2) @(posedge clk);
                    {count_pin_a, count_pin_b} <= 2'b11;
                    repeat (2) @(posedge clk);
                end
                done <= 1'b1;
            end
        end
    end
endmodule : pin_source

// ---- bench/dual_counter_timer_tb.sv ----
/* Bench: Wishbone tasks, pin source, integer model of the count.
 Assumes the registered ack and count latency of the design note. */
`timescale 1ns/100ps
module dual_counter_timer_tb;
    import tmr_pkg::*;
    logic clk, reset_n, start, pick_b, done, pin_a, pin_b, gate_a, gate_b;
    logic ext_clk, split_t2, split_t3, ext_clk_tick, irq_t0, irq_t1, lo_t2, lo_t3;
    logic [3:0] edges;
    wb_req_type wb_req;
    wb_rsp_type wb_rsp;
    logic [31:0] rd;
    int errors, checks, cycles, t, m, g, n, pre, v, lo, hi, ovf;
    int seed = 32'hfcdf;
    dual_counter_timer dut (.clk(clk), .reset_n(reset_n), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .count_pin_a(pin_a), .count_pin_b(pin_b),
        .gate_input_a(gate_a), .gate_input_b(gate_b), .ext_clk(ext_clk),
        .split_t2(split_t2), .split_t3(split_t3), .ext_clk_tick(ext_clk_tick),
        .irq_t0(irq_t0), .irq_t1(irq_t1), .t1_overflow_pulse(), .hi_tick_t2(),
        .lo_tick_t2(lo_t2), .hi_tick_t3(), .lo_tick_t3(lo_t3));
    pin_source src (.clk(clk), .start(start), .pick_b(pick_b), .edges(edges),
        .count_pin_a(pin_a), .count_pin_b(pin_b), .done(done));
    // =====
    // Clock, hang guard and random side inputs
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    always @(posedge clk) begin
        {ext_clk, split_t2, split_t3, ext_clk_tick} <= 4'($random(seed));
    end
    // =====
    // Verdict, bus cycle and comparisons
    task automatic results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic wb(input logic we, input logic [7:0] a, input int d, input logic [3:0] s);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: 32'(d)};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb
    task automatic chk_byte(input logic [7:0] got, input int exp);
        checks++;
        if (got !== exp[7:0])
            $display("unexpected %0t byte %h want %h", $time, got, exp[7:0]);
        if (got !== exp[7:0])
            errors++;
    endtask : chk_byte
    task automatic chk_flag(input logic got, input int exp);
        checks++;
        if (got !== exp[0])
            $display("unexpected %0t flag %b want %0d", $time, got, exp);
        if (got !== exp[0])
            errors++;
    endtask : chk_flag
    // =====
    // Main sequence: reset values, then every count mode on both timers
    initial begin
        {start, pick_b, gate_a, gate_b, edges} = '0;
        wb_req = '0;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        wb(0, ADDR_MODE_SELECT, 0, 4'h1);
        chk_byte(rd[7:0], 0);
        wb(0, ADDR_CLOCK_CONTROL, 0, 4'h1);
        chk_byte(rd[7:0], 0);
        pre = ($random(seed) & 255) | 8'h50; // Low-byte selects held on for timers 2/3
        wb(1, ADDR_CLOCK_CONTROL, pre, 4'h1);
        wb(0, ADDR_CLOCK_CONTROL, 0, 4'h1);
        chk_byte(rd[7:0], pre);
        chk_flag(lo_t2 && lo_t3, 1);
        for (t = 0; t < 2; t++) begin
            for (m = 0; m < 4; m++) begin
                pre = $random(seed) & 16'hffff;
                n = 1 + ($random(seed) & 7);
                g = $random(seed) & 3; // Bit 0 gate enable, bit 1 gate level
                wb(1, ADDR_MODE_SELECT, ((g[0] << 3) | 4 | m) << (4 * t), 4'h1);
                wb(1, t ? ADDR_LOW_T1 : ADDR_LOW_T0, pre & 255, 4'h1);
                wb(1, t ? ADDR_HIGH_T1 : ADDR_HIGH_T0, pre >> 8, 4'h1);
                gate_a <= g[1];
                gate_b <= g[1];
                wb(1, ADDR_CONTROL_STATUS, (1 << (4 + 2 * t)) | (1 << (8 + t)), 4'h3);
                pick_b <= t[0];
                edges <= n[3:0];
                start <= 1'b1;
                @(posedge clk);
                start <= 1'b0;
                repeat (2) @(posedge clk);
                while (done !== 1'b1) @(posedge clk);
                repeat (3) @(posedge clk);
                // Gate enabled and its input away from polarity 0 holds the count
                if (g == 3)
                    n = 0;
                lo = pre & 255;
                hi = pre >> 8;
                v = (m == 0) ? hi * 32 + (lo & 31) + n : pre + n;
                ovf = (m == 0) ? v > 8191 : v > 65535;
                hi = (m == 0) ? (v >> 5) & 255 : (v >> 8) & 255;
                lo = (m == 0) ? (lo & 224) | (v & 31) : v & 255;
                // Mode 3: timer 0 low byte wraps to zero, timer 1 is stopped
                if (m >= 2) begin
                    lo = pre & 255;
                    hi = pre >> 8;
                    ovf = 0;
                    repeat ((m == 3) ? n * (1 - t) : n) begin
                        lo++;
                        ovf = ovf | (lo == 256);
                        lo = (lo == 256) ? ((m == 2) ? hi : 0) : lo;
                    end
                end
                wb(0, t ? ADDR_LOW_T1 : ADDR_LOW_T0, 0, 4'h1);
                chk_byte(rd[7:0], lo);
                wb(0, t ? ADDR_HIGH_T1 : ADDR_HIGH_T0, 0, 4'h1);
                chk_byte(rd[7:0], hi);
                wb(0, ADDR_CONTROL_STATUS, 0, 4'h3);
                chk_flag(rd[5 + 2 * t], ovf);
                chk_flag(t ? irq_t1 : irq_t0, ovf);
                wb(1, ADDR_CONTROL_STATUS, 0, 4'h3);
            end
        end
        results();
    end
endmodule : dual_counter_timer_tb
